// ### pkg/downcount_timer_consts.svh
// Register map, field positions, reset values and timing counts of the down-count timer
//--------------------------------------------------------------------------------------
//--------------------------------------------------------------------------------------
`ifndef DOWNCOUNT_TIMER_CONSTS_SVH
`define DOWNCOUNT_TIMER_CONSTS_SVH

// Register offsets (byte addresses)
`define OFS_COUNT 8'h00
`define OFS_PRELOAD 8'h04
`define OFS_CONTROL 8'h08
`define OFS_SOFT_IRQ 8'h0C

// Control field positions
`define CTL_ENABLE 0
`define CTL_RELOAD 1
`define CTL_START 2
`define CTL_DEBUG_PAUSE 3
`define CTL_FW_HALT 4
`define CTL_WIDTH 5

// Soft interrupt field width
`define SOFT_IRQ_BITS 4

// Reset values
`define COUNT_RESET 32'h0000_0000
`define PRELOAD_RESET 32'h0000_0000
`define CONTROL_RESET 5'h00

// Timing: system clock and timer tick rate in Hz
`define CLK_HZ 100000000
`define TICK_HZ 32768
`define TICK_DIV (`CLK_HZ / `TICK_HZ)
`define TICK_CNT_W 12

`endif

// ### pkg/downcount_timer_pkg.sv
// Types shared by the down-count timer design
package downcount_timer_pkg;

    // Counter run state
    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } run_state_e;

    typedef logic [31:0] word_t;

endpackage

// ### hdl/tick_divider.sv
// Divider that turns the system clock into a one-cycle 32 kHz tick enable
`timescale 1ns/1ps
`include "downcount_timer_consts.svh"

module tick_divider (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Tick enable
    output logic tick
);

    logic [`TICK_CNT_W-1:0] div_q;
    logic [`TICK_CNT_W-1:0] div_d;
    logic wrap;

    // Wrap after TICK_DIV cycles; the fraction is dropped, so the tick runs slightly fast
    assign wrap = (div_q == `TICK_CNT_W'(`TICK_DIV - 1));
    assign div_d = wrap ? '0 : div_q + `TICK_CNT_W'(1);

    // Free-running prescaler
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_q <= '0;
            tick <= 1'b0;
        end else begin
            div_q <= div_d;
            tick <= wrap;
        end
    end

endmodule

// ### hdl/downcount_timer.sv
// Low-power down-count timer with control and software interrupt registers
`timescale 1ns/1ps
`include "downcount_timer_consts.svh"

module downcount_timer
    import downcount_timer_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Debug halt, shared with the processor halt
    input wire logic debug_halt,
    // Interrupt events
    output logic countdown_irq,
    output logic [`SOFT_IRQ_BITS-1:0] soft_irq
);

    //----------------------------------------------------------------------
    // State
    //----------------------------------------------------------------------
    word_t count_q;
    word_t count_d;
    word_t preload_q;
    word_t preload_d;
    run_state_e state_q;
    run_state_e state_d;
    logic enable_q;
    logic enable_d;
    logic reload_q;
    logic reload_d;
    logic debug_pause_q;
    logic debug_pause_d;
    logic fw_halt_q;
    logic fw_halt_d;
    logic irq_d;
    logic tick;

    //----------------------------------------------------------------------
    // Tick enable
    //----------------------------------------------------------------------
    // The counter steps on this enable so the timer keeps a single clock domain
    tick_divider u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick)
    );

    //----------------------------------------------------------------------
    // Address decode
    //----------------------------------------------------------------------
    logic hit_count;
    logic hit_preload;
    logic hit_control;
    logic hit_soft;
    logic wr_count;
    logic wr_preload;
    logic wr_control;
    logic wr_soft;

    // Offsets decoded by if-style priority through plain compares
    assign hit_count = (reg_addr == `OFS_COUNT);
    assign hit_preload = (reg_addr == `OFS_PRELOAD);
    assign hit_control = (reg_addr == `OFS_CONTROL);
    assign hit_soft = (reg_addr == `OFS_SOFT_IRQ);
    assign wr_count = reg_wr && hit_count;
    assign wr_preload = reg_wr && hit_preload;
    assign wr_control = reg_wr && hit_control;
    assign wr_soft = reg_wr && hit_soft;

    //----------------------------------------------------------------------
    // Control write fields
    //----------------------------------------------------------------------
    logic new_enable;
    logic new_start;
    logic start_rise;
    logic start_fall;
    logic preload_zero;

    assign new_enable = reg_wdata[`CTL_ENABLE];
    assign new_start = reg_wdata[`CTL_START];
    assign preload_zero = (preload_q == '0);
    // Only a 0-to-1 write of start loads, so rewriting control to flip a halt
    // bit does not restart a running count
    assign start_rise = wr_control && new_enable && new_start && (state_q == ST_IDLE);
    assign start_fall = wr_control && !new_start && (state_q == ST_RUN);

    //----------------------------------------------------------------------
    // Pause and step conditions
    //----------------------------------------------------------------------
    logic hw_pause;
    logic counting;
    logic step;
    logic at_one;

    // Debug input only counts when its enable is set
    assign hw_pause = debug_pause_q && debug_halt;
    assign counting = enable_q && (state_q == ST_RUN) && !fw_halt_q && !hw_pause;
    assign step = tick && counting && (count_q != '0);
    assign at_one = (count_q == 32'h0000_0001);

    //----------------------------------------------------------------------
    // Next-state logic
    //----------------------------------------------------------------------
    // A control, count or preload write in the same cycle as a tick wins over the tick
    always_comb begin
        count_d = count_q;
        preload_d = preload_q;
        state_d = state_q;
        enable_d = enable_q;
        reload_d = reload_q;
        debug_pause_d = debug_pause_q;
        fw_halt_d = fw_halt_q;
        irq_d = 1'b0;
        if (wr_control && !new_enable) begin
            // Disabling returns every register bit to its default
            count_d = `COUNT_RESET;
            preload_d = `PRELOAD_RESET;
            state_d = ST_IDLE;
            enable_d = 1'b0;
            reload_d = 1'b0;
            debug_pause_d = 1'b0;
            fw_halt_d = 1'b0;
        end else if (wr_control) begin
            enable_d = 1'b1;
            reload_d = reg_wdata[`CTL_RELOAD];
            debug_pause_d = reg_wdata[`CTL_DEBUG_PAUSE];
            fw_halt_d = reg_wdata[`CTL_FW_HALT];
            if (start_rise) begin
                if (preload_zero) begin
                    state_d = ST_IDLE;
                end else begin
                    count_d = preload_q;
                    state_d = ST_RUN;
                end
            end else if (start_fall) begin
                count_d = '0;
                state_d = ST_IDLE;
            end
        end else if (wr_count) begin
            count_d = reg_wdata;
        end else if (wr_preload) begin
            // Preload only reaches the counter on start or on reload
            preload_d = reg_wdata;
        end else if (step) begin
            case (state_q)
                ST_RUN: begin
                    if (at_one) begin
                        irq_d = 1'b1;
                        if (reload_q) begin
                            count_d = preload_q;
                        end else begin
                            count_d = '0;
                            state_d = ST_IDLE;
                        end
                    end else begin
                        count_d = count_q - 32'h0000_0001;
                    end
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
        // A preload write on a different cycle than the step is handled above
        if (wr_preload && step && at_one && reload_q) begin
            preload_d = reg_wdata;
        end
    end

    //----------------------------------------------------------------------
    // Timer registers
    //----------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_q <= `COUNT_RESET;
            preload_q <= `PRELOAD_RESET;
            state_q <= ST_IDLE;
            enable_q <= 1'b0;
            reload_q <= 1'b0;
            debug_pause_q <= 1'b0;
            fw_halt_q <= 1'b0;
        end else begin
            count_q <= count_d;
            preload_q <= preload_d;
            state_q <= state_d;
            enable_q <= enable_d;
            reload_q <= reload_d;
            debug_pause_q <= debug_pause_d;
            fw_halt_q <= fw_halt_d;
        end
    end

    //----------------------------------------------------------------------
    // Interrupt events
    //----------------------------------------------------------------------
    logic [`SOFT_IRQ_BITS-1:0] soft_d;

    // One pulse per written one; zeros in the write leave the line quiet
    genvar gi;
    generate
        for (gi = 0; gi < `SOFT_IRQ_BITS; gi = gi + 1) begin : g_soft
            assign soft_d[gi] = wr_soft && reg_wdata[gi];
        end
    endgenerate

    // Event outputs are one-cycle pulses straight from flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            countdown_irq <= 1'b0;
            soft_irq <= '0;
        end else begin
            countdown_irq <= irq_d;
            soft_irq <= soft_d;
        end
    end

    //----------------------------------------------------------------------
    // Read path
    //----------------------------------------------------------------------
    logic [`CTL_WIDTH-1:0] ctl_view;
    word_t rd_mux;

    // Reserved control bits and the whole soft register read as zero
    assign ctl_view = {fw_halt_q, debug_pause_q, (state_q == ST_RUN), reload_q, enable_q};
    assign rd_mux = hit_count ? count_q :
                    hit_preload ? preload_q :
                    hit_control ? {27'h0, ctl_view} :
                    '0;

    // Read data is registered and valid for one cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
            reg_rvalid <= reg_rd;
        end
    end

endmodule

// ### tb/downcount_timer_asserts.sv
// Port checker for the down-count timer
`timescale 1ns/1ps
`include "downcount_timer_consts.svh"
module downcount_timer_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    // Halt and events
    input wire logic debug_halt,
    input wire logic countdown_irq,
    input wire logic [`SOFT_IRQ_BITS-1:0] soft_irq
);
    // -----
    // Properties
    // -----
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [11:0] up_q;
    // Cycles since reset; no tick can come before the divider first wraps
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            up_q <= 12'h000;
        end else if (up_q != 12'hFFF) begin
            up_q <= up_q + 12'h001;
        end
    end
    property p_soft_read;
        reg_rd && reg_addr == 8'h0C |=> reg_rvalid && reg_rdata == 32'h0;
    endproperty
    a_soft_read: assert property (p_soft_read) else $error("soft read not zero");
    property p_ctl_rsvd;
        reg_rd && reg_addr == 8'h08 |=> reg_rvalid && reg_rdata[31:5] == 27'h0;
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control reserved set");
    property p_soft_evt;
        reg_wr && reg_addr == 8'h0C |=> soft_irq == $past(reg_wdata[3:0]);
    endproperty
    a_soft_evt: assert property (p_soft_evt) else $error("soft event wrong");
    property p_soft_quiet;
        !(reg_wr && reg_addr == 8'h0C) |=> soft_irq == 4'h0;
    endproperty
    a_soft_quiet: assert property (p_soft_quiet) else $error("soft event unasked");
    property p_first_tick;
        countdown_irq |-> up_q >= `TICK_DIV;
    endproperty
    a_first_tick: assert property (p_first_tick) else $error("irq before first tick");
    property p_stop_quiet;
        reg_wr && reg_addr == 8'h08 && !reg_wdata[2] |=> !countdown_irq [*2];
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("irq after stop");
    property p_start_en;
        reg_rvalid && $past(reg_rd && reg_addr == 8'h08) |-> !reg_rdata[2] || reg_rdata[0];
    endproperty
    a_start_en: assert property (p_start_en) else $error("running while off");
    property p_irq_gap;
        countdown_irq |=> !countdown_irq [*8];
    endproperty
    a_irq_gap: assert property (p_irq_gap) else $error("irq too close");
endmodule

bind downcount_timer downcount_timer_asserts chk_u (.ref_clk(ref_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .debug_halt(debug_halt),
    .countdown_irq(countdown_irq), .soft_irq(soft_irq));

// ### tb/halt_source.sv
// Model of the processor debug halt line
`timescale 1ns/1ps
module halt_source (
    // Clock
    input wire logic ref_clk,
    // Bench request and halt line
    input wire logic halt_req,
    output logic debug_halt
);
    // Registered, so the shared halt level moves only after an edge
    always_ff @(posedge ref_clk) begin
        debug_halt <= halt_req;
    end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the down-count timer
`timescale 1ns/1ps
`include "downcount_timer_consts.svh"
module testbench;
    import downcount_timer_pkg::*;
    logic ref_clk, rst, reg_wr, reg_rd, reg_rvalid, halt_req, debug_halt, countdown_irq;
    logic [7:0] reg_addr;
    word_t reg_wdata, reg_rdata;
    logic [3:0] soft_irq;
    int n_fail = 0, checks_done = 0, cyc = 0, n_irq = 0, n0, t0, t1, k;
    downcount_timer dut_u (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .debug_halt(debug_halt), .countdown_irq(countdown_irq),
        .soft_irq(soft_irq));
    halt_source halt_u (.ref_clk(ref_clk), .halt_req(halt_req), .debug_halt(debug_halt));
    // -----
    // Clock, watchdog and tasks
    // -----
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Watchdog sized well above the ~16 ticks the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (countdown_irq === 1'b1) n_irq++;
        if (cyc == 90000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input word_t d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Answer stands one cycle, so it is sampled just after the answering edge
    task automatic rd(input logic [7:0] a, input word_t exp, input string nm);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, reg_rdata, exp);
    endtask
    // Bounded wait for the timer event; records the cycle of the last two
    task automatic wait_irq();
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (countdown_irq !== 1'b1 && k < 7000);
        chk("irq", {31'h0, countdown_irq}, 32'h1);
        t0 = t1;
        t1 = cyc;
    endtask
    // -----
    // Main sequence
    // -----
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        halt_req = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h08, 32'h0, "ctl_reset");
        wr(8'h08, 32'hFFFF_FFE1);
        rd(8'h08, 32'h1, "ctl_rsvd");
        for (int i = 0; i < 4; i++) begin
            wr(8'h0C, 32'h1 << i);
            #1 chk("soft_irq", {28'h0, soft_irq}, 32'h1 << i);
        end
        wr(8'h0C, 32'h0);
        #1 chk("soft_irq", {28'h0, soft_irq}, 32'h0);
        rd(8'h0C, 32'h0, "soft_read");
        rd(8'h10, 32'h0, "unmapped");
        wr(8'h08, 32'h5);
        rd(8'h08, 32'h1, "start_zero");
        // Continuous mode; a new preload waits for the next reload
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h7);
        wait_irq();
        wr(8'h04, 32'h2);
        wait_irq();
        chk("gap", t1 - t0, `TICK_DIV);
        wait_irq();
        chk("gap", t1 - t0, 2 * `TICK_DIV);
        // Firmware halt, then debug pause, then the halt line ignored
        wr(8'h08, 32'h17);
        repeat (2 * `TICK_DIV) @(posedge ref_clk);
        rd(8'h00, 32'h2, "count_held");
        halt_req <= 1'b1;
        wr(8'h08, 32'hF);
        repeat (`TICK_DIV) @(posedge ref_clk);
        rd(8'h00, 32'h2, "count_paused");
        wr(8'h08, 32'h7);
        wait_irq();
        chk("gap", t1 - t0, 5 * `TICK_DIV);
        // Halt line drops before the one-shot part; debug pause is already off, so the count is unaffected
        halt_req <= 1'b0;
        // One-shot ending, restart, then stop by clearing start
        wr(8'h08, 32'h5);
        wait_irq();
        rd(8'h08, 32'h1, "oneshot_ctl");
        n0 = n_irq;
        repeat (2 * `TICK_DIV) @(posedge ref_clk);
        chk("irq_count", n_irq, n0);
        wr(8'h08, 32'hD);
        rd(8'h00, 32'h2, "start_load");
        repeat (`TICK_DIV) @(posedge ref_clk);
        rd(8'h00, 32'h1, "count_step");
        n0 = n_irq;
        wr(8'h08, 32'h1);
        rd(8'h00, 32'h0, "stop_clear");
        repeat (2 * `TICK_DIV) @(posedge ref_clk);
        chk("irq_count", n_irq, n0);
        // Direct count write, then disabling must clear count and preload alike
        wr(8'h00, 32'h3);
        rd(8'h00, 32'h3, "count_wr");
        wr(8'h04, 32'h9);
        wr(8'h08, 32'h0);
        rd(8'h04, 32'h0, "preload_off");
        rd(8'h00, 32'h0, "count_off");
        // System reset with every control field but start set must clear them again
        wr(8'h08, 32'h1B);
        rd(8'h08, 32'h1B, "ctl_set");
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h08, 32'h0, "ctl_rerst");
        print_verdict();
    end
endmodule
